// [tb_top.sv]
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("wrong value at %0t: %h vs %h", $time, (g), (e)); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr, herr, perr;
  logic [7:0] wdata, rdata, d;
  logic [6:0] lvl, txl;
  logic rd, wr, irq, slp, ovrn, push, xoff, xon, ferr, thre, temt, dlt, rts_n, cts_n;
  bit fm;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  uiep_host i_host (.sys_clk_i, .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .rd_o(rd), .wr_o(wr));
  uiep_core i_uiep_core (.sys_clk_i, .rst_i, .addr_i(addr), .wdata_i(wdata), .rd_i(rd), .wr_i(wr),
    .rdata_o(rdata), .rx_level_i(lvl), .rx_push_i(push), .rx_push_err_i(perr), .rx_head_err_i(herr),
    .rx_fifo_err_i(ferr), .rx_overrun_i(ovrn), .thr_empty_i(thre), .tx_empty_i(temt), .tx_level_i(txl),
    .msr_delta_i(dlt), .xoff_det_i(xoff), .xon_det_i(xon), .rts_n_i(rts_n), .cts_n_i(cts_n), .irq_o(irq),
    .fifo_en_o(), .sleep_en_o(slp), .rhr_rd_o(), .thr_wr_o(), .msr_rd_o());
  always #20 sys_clk_i = ~sys_clk_i;
  // ====================
  // hang guard, run needs well under a thousand cycles
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  // line status as the bench expects it from what it drives
  function automatic logic [7:0] lsr_exp(input logic o);
    return {ferr & fm, temt, thre, (lvl != 0) ? herr : 3'h0, o, lvl != 0};
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    {lvl, txl, herr, perr, ferr, thre, temt, dlt, push, ovrn, xoff, xon} = '0;
    {rts_n, cts_n} = 2'b11;
    void'($urandom(29968));
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    i_host.get(3'h1, d); `CHK(d, 8'h00)
    i_host.get(3'h2, d); `CHK(d, 8'h01)
    i_host.put(3'h4, 8'hFF);
    i_host.get(3'h4, d); `CHK(d, 8'h00)
    // polled status, fifo off then on, all sources masked
    for (int f = 0; f < 2; f++) begin
      i_host.put(3'h2, 8'(f));
      fm = f[0];
      repeat (8) begin
        @(posedge sys_clk_i);
        lvl <= 7'($urandom_range(64));
        txl <= 7'($urandom_range(64));
        {herr, perr, ferr, thre, temt, dlt, rts_n, cts_n} <= 12'($urandom);
        i_host.get(3'h5, d); `CHK(d, lsr_exp(1'b0))
        `CHK(irq, 1'b0)
      end
    end
    // transmit ready raised at once when enabled while empty
    @(posedge sys_clk_i);
    {lvl, herr, thre} <= {7'h00, 3'h0, 1'b1};
    i_host.put(3'h2, 8'h00);
    fm = 1'b0;
    i_host.put(3'h1, 8'h02);
    tick(1); `CHK(irq, 1'b1)
    i_host.get(3'h2, d); `CHK(d, 8'h02)
    tick(2); `CHK(irq, 1'b0)
    // overrun raises line interrupt, status read clears it
    i_host.put(3'h2, 8'h01);
    fm = 1'b1;
    i_host.put(3'h1, 8'h04);
    i_host.get(3'h5, d);
    @(posedge sys_clk_i);
    ovrn <= 1'b1;
    @(posedge sys_clk_i);
    ovrn <= 1'b0;
    tick(2); `CHK(irq, 1'b1)
    i_host.get(3'h5, d); `CHK(d, lsr_exp(1'b1))
    i_host.get(3'h5, d); `CHK(d, lsr_exp(1'b0))
    `CHK(irq, 1'b0)
    // receive trigger at level one, then below it
    i_host.put(3'h1, 8'h01);
    for (int k = 1; k >= 0; k--) begin
      @(posedge sys_clk_i);
      lvl <= 7'(k);
      tick(3); `CHK(irq, k[0])
      i_host.get(3'h2, d); `CHK(d, k[0] ? 8'hC4 : 8'hC1)
    end
    // sleep bit refused until enhanced mode is on
    i_host.put(3'h1, 8'h10);
    tick(1); `CHK(slp, 1'b0)
    i_host.put(3'h3, 8'hBF);
    i_host.put(3'h2, 8'h10);
    i_host.put(3'h3, 8'h03);
    i_host.put(3'h1, 8'h10);
    tick(1); `CHK(slp, 1'b1)
    i_host.get(3'h1, d); `CHK(d, 8'h10)
    // rts and cts rising edges, cleared by a modem status read
    i_host.put(3'h1, 8'hC0);
    @(posedge sys_clk_i);
    {rts_n, cts_n} <= 2'b00;
    tick(2); `CHK(irq, 1'b0)
    @(posedge sys_clk_i);
    rts_n <= 1'b1;
    tick(3); `CHK(irq, 1'b1)
    i_host.get(3'h2, d); `CHK(d, 8'hE0)
    i_host.get(3'h6, d);
    tick(2); `CHK(irq, 1'b0)
    @(posedge sys_clk_i);
    cts_n <= 1'b1;
    tick(3); `CHK(irq, 1'b1)
    i_host.get(3'h6, d);
    tick(2); `CHK(irq, 1'b0)
    // pause character interrupt, acknowledged by a source read
    i_host.put(3'h1, 8'h20);
    @(posedge sys_clk_i);
    xoff <= 1'b1;
    @(posedge sys_clk_i);
    xoff <= 1'b0;
    tick(2); `CHK(irq, 1'b1)
    i_host.get(3'h2, d); `CHK(d, 8'hD0)
    tick(2); `CHK(irq, 1'b0)
    // delayed error interrupt once an errored byte is at the head
    i_host.put(3'h1, 8'h04);
    @(posedge sys_clk_i);
    {lvl, herr} <= {7'h01, 3'h2};
    tick(3); `CHK(irq, 1'b1)
    i_host.get(3'h5, d); `CHK(d, lsr_exp(1'b0))
    tick(2); `CHK(irq, 1'b0)
    wrap_up();
  end
endmodule // tb_top

// [uiep_core.v]
// How it works
// RULE_01: mask gates four sources, reported in status
// RULE_02: rx interrupt at trigger, drops below it
// RULE_03: status bits 2,3 follow rx trigger; the rx trigger source code 04 sets only bit 2
// RULE_04: data ready set on push, clear empty
// RULE_05: fifo on, mask 0-3 clear: polled
// RULE_06: line bit 1 flags overrun
// RULE_07: line bits 2-4 show head byte errors
// RULE_08: bit 5 holding empty, bit 6 all empty
// RULE_09: bit 7 any errored byte in fifo
// RULE_10: mask 0 enables receive data interrupt
// RULE_11: mask 1 enables transmit ready interrupt
// RULE_12: enabling with holding empty interrupts immediately
// RULE_13: mask 2: line bits 1-4 interrupt
// RULE_14: overrun immediate, errors at read-out
// RULE_15: extended mode bit 6: errors immediate
// RULE_16: mask 3 enables modem interrupt, reset off
// RULE_17: mask 4 sleep, needs enhanced enable
// RULE_18: mask 5 pause interrupt, needs enhanced
// RULE_19: mask 6 rts rising interrupt
// RULE_20: mask 7 cts rising interrupt
// RULE_21: interrupt output follows any enabled pending
`include "uiep_map.vh"
module uiep_core (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire rd_i,
  input wire wr_i,
  output reg [7:0] rdata_o,
  input wire [6:0] rx_level_i,
  input wire rx_push_i,
  input wire [2:0] rx_push_err_i,
  input wire [2:0] rx_head_err_i,
  input wire rx_fifo_err_i,
  input wire rx_overrun_i,
  input wire thr_empty_i,
  input wire tx_empty_i,
  input wire [6:0] tx_level_i,
  input wire msr_delta_i,
  input wire xoff_det_i,
  input wire xon_det_i,
  input wire rts_n_i,
  input wire cts_n_i,
  output reg irq_o,
  output wire fifo_en_o,
  output wire sleep_en_o,
  output wire rhr_rd_o,
  output wire thr_wr_o,
  output wire msr_rd_o
);

  // =====================================
  // trigger table lookup
  // table A fixed steps; other tables use the
  // programmed trigger byte (low 7 bits)
  function [6:0] trig_lvl;
    input [1:0] tbl;
    input [1:0] sel;
    input [7:0] prog;
    begin
      if (tbl != 2'h0) begin
        trig_lvl = prog[6:0];
      end else begin
        case (sel)
          2'h0: trig_lvl = 7'h01;
          2'h1: trig_lvl = 7'h04;
          2'h2: trig_lvl = 7'h08;
          default: trig_lvl = 7'h0E;
        endcase
      end
    end
  endfunction

  // =====================================
  // programmable registers
  reg [7:0] mask_reg; // interrupt_mask_reg
  reg [7:0] lcr_reg; // line_control_reg
  reg [7:0] fcr_reg; // fifo_control_reg
  reg [7:0] efr_reg; // enhanced_feature_reg
  reg [7:0] feature_control_reg; // feature_control
  reg [7:0] extended_mode_reg_reg; // extended_mode_reg
  reg [7:0] trg_reg; // trigger byte
  reg [7:0] spr_reg; // scratch
  reg [7:0] resume_char_one_reg;
  reg [7:0] resume_char_two_reg;
  reg [7:0] pause_char_one_reg;
  reg [7:0] pause_char_two_reg;

  // =====================================
  // sticky interrupt state
  reg ovr_reg; // overrun flag
  reg lsr_int_reg; // line status pending
  reg tx_int_reg; // transmit ready pending
  reg xoff_int_reg; // pause char pending
  reg flow_int_reg; // rts/cts rising pending
  reg tx_low_reg; // last transmit-ready level
  reg head_err_reg; // last head-error level
  reg rts_n_reg; // previous rts level
  reg cts_n_reg; // previous cts level

  // =====================================
  // decode helpers
  wire enh_bank = (lcr_reg == `UIEP_LCR_ENH);
  wire div_bank = lcr_reg[`UIEP_LCR_DIV];
  wire enh_en = efr_reg[`UIEP_EFR_ENH];
  wire fifo_en = fcr_reg[`UIEP_FCR_EN];
  wire nrm = !enh_bank && !div_bank;
  wire wr_mask = wr_i && nrm && addr_i == `UIEP_A_MASK;
  wire wr_fcr = wr_i && nrm && addr_i == `UIEP_A_ISR;
  wire rd_isr = rd_i && nrm && addr_i == `UIEP_A_ISR;
  wire rd_lsr = rd_i && !enh_bank && addr_i == `UIEP_A_LSR;
  wire wr_extended_mode_reg = wr_i && !enh_bank && addr_i == `UIEP_A_SPR
    && feature_control_reg[`UIEP_FEATURE_CONTROL_EXTENDED_MODE_REG];

  // side-effect strobes for the fifo and modem logic
  assign rhr_rd_o = rd_i && nrm && addr_i == `UIEP_A_DATA;
  assign thr_wr_o = wr_i && nrm && addr_i == `UIEP_A_DATA;
  assign msr_rd_o = rd_i && !enh_bank && addr_i == `UIEP_A_MSR;
  assign fifo_en_o = fifo_en;
  assign sleep_en_o = mask_reg[4]; // RULE_17

  // =====================================
  // receive and transmit conditions
  wire [6:0] rx_trig = trig_lvl(feature_control_reg[5:4], fcr_reg[7:6], trg_reg);
  wire [6:0] tx_trig = trig_lvl(feature_control_reg[5:4], fcr_reg[5:4], trg_reg);
  wire rx_rdy = (rx_level_i != 7'h00); // RULE_04
  // fifo mode waits for the trigger, otherwise one byte
  wire rx_hit = fifo_en ? (rx_level_i >= rx_trig) : rx_rdy; // RULE_02 RULE_10
  // transmit ready: below trigger in fifo mode, else holding empty
  wire tx_low = fifo_en ? (tx_level_i < tx_trig) : thr_empty_i; // RULE_11
  // only a byte actually at the head can report errors
  wire [2:0] head_err = rx_rdy ? rx_head_err_i : 3'h0; // RULE_07
  wire head_bad = |head_err;
  wire imd = extended_mode_reg_reg[`UIEP_EXTENDED_MODE_REG_IMD];

  // =====================================
  // line status word
  wire [7:0] lsr_val = {
    fifo_en & rx_fifo_err_i, // RULE_09
    tx_empty_i, // RULE_08
    thr_empty_i, // RULE_08
    head_err[2],
    head_err[1],
    head_err[0],
    ovr_reg, // RULE_06
    rx_rdy};

  // =====================================
  // gated sources; all mask bits clear leaves
  // these low so software polls the line status
  wire src_lsr = mask_reg[2] & lsr_int_reg; // RULE_13 RULE_05
  wire src_rxd = mask_reg[0] & rx_hit; // RULE_01 RULE_02
  wire src_tx = mask_reg[1] & tx_int_reg; // RULE_01
  wire src_msr = mask_reg[3] & msr_delta_i; // RULE_16
  wire src_xoff = mask_reg[5] & xoff_int_reg; // RULE_18
  wire src_flow = (mask_reg[6] | mask_reg[7]) & flow_int_reg;
  wire any_src = src_lsr | src_rxd | src_tx | src_msr | src_xoff | src_flow;

  // =====================================
  // priority encoder for the source register
  reg [5:0] isr_code;
  always @* begin
    if (src_lsr) begin
      isr_code = `UIEP_ISR_LSR;
    end else if (src_rxd) begin
      isr_code = `UIEP_ISR_RXD; // RULE_03
    end else if (src_tx) begin
      isr_code = `UIEP_ISR_TX;
    end else if (src_msr) begin
      isr_code = `UIEP_ISR_MSR;
    end else if (src_xoff) begin
      isr_code = `UIEP_ISR_XOFF;
    end else if (src_flow) begin
      isr_code = `UIEP_ISR_FLOW;
    end else begin
      isr_code = `UIEP_ISR_NONE;
    end
  end

  // reading the source register acknowledges tx ready
  // only when that was the reported source
  wire isr_tx_ack = rd_isr && isr_code == `UIEP_ISR_TX;
  wire isr_xoff_ack = rd_isr && isr_code == `UIEP_ISR_XOFF;

  // =====================================
  // event detectors
  wire rts_rise = rts_n_reg == 1'b0 && rts_n_i; // RULE_19
  wire cts_rise = cts_n_reg == 1'b0 && cts_n_i; // RULE_20
  wire flow_set = (mask_reg[6] & enh_en & rts_rise) | (mask_reg[7] & enh_en & cts_rise);
  // delayed mode: errored byte reaches the read position
  wire err_dly = !imd && head_bad && !head_err_reg; // RULE_14
  wire err_imd = imd && rx_push_i && (|rx_push_err_i); // RULE_15
  wire lsr_set = rx_overrun_i | err_dly | err_imd; // RULE_14
  // tx ready rising, or mask bit 1 turned on while already empty
  wire tx_set = (tx_low && !tx_low_reg) || (wr_mask && wdata_i[1] && !mask_reg[1] && tx_low); // RULE_12

  // =====================================
  // register writes
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      mask_reg <= `UIEP_RST_BYTE; // RULE_16
      lcr_reg <= `UIEP_RST_LCR;
      fcr_reg <= `UIEP_RST_BYTE;
      efr_reg <= `UIEP_RST_BYTE;
      feature_control_reg <= `UIEP_RST_BYTE;
      extended_mode_reg_reg <= `UIEP_RST_BYTE;
      trg_reg <= `UIEP_RST_BYTE;
      spr_reg <= `UIEP_RST_BYTE;
      resume_char_one_reg <= `UIEP_RST_BYTE;
      resume_char_two_reg <= `UIEP_RST_BYTE;
      pause_char_one_reg <= `UIEP_RST_BYTE;
      pause_char_two_reg <= `UIEP_RST_BYTE;
    end else begin
      // line control reachable from every bank
      if (wr_i && addr_i == `UIEP_A_LCR) begin
        lcr_reg <= wdata_i;
      end
      // upper mask bits are frozen unless enhanced
      if (wr_mask) begin
        mask_reg[3:0] <= wdata_i[3:0]; // RULE_01
        if (enh_en) begin
          mask_reg[7:4] <= wdata_i[7:4]; // RULE_17 RULE_18 RULE_19 RULE_20
        end
      end
      // other fifo bits only stick with bit 0 set
      if (wr_fcr) begin
        fcr_reg[0] <= wdata_i[0];
        if (wdata_i[0]) begin
          fcr_reg[7:6] <= wdata_i[7:6];
          fcr_reg[3] <= wdata_i[3];
          if (enh_en) begin
            fcr_reg[5:4] <= wdata_i[5:4];
          end
        end
      end
      if (wr_extended_mode_reg) begin
        extended_mode_reg_reg <= wdata_i; // RULE_15
      end
      if (wr_i && !enh_bank && addr_i == `UIEP_A_SPR && !feature_control_reg[`UIEP_FEATURE_CONTROL_EXTENDED_MODE_REG]) begin
        spr_reg <= wdata_i;
      end
      // enhanced bank
      if (wr_i && enh_bank) begin
        case (addr_i)
          `UIEP_A_TRG: trg_reg <= wdata_i;
          `UIEP_A_FEATURE_CONTROL: feature_control_reg <= wdata_i;
          `UIEP_A_EFR: efr_reg <= wdata_i;
          `UIEP_A_RESUME_CHAR_ONE: resume_char_one_reg <= wdata_i;
          `UIEP_A_RESUME_CHAR_TWO: resume_char_two_reg <= wdata_i;
          `UIEP_A_PAUSE_CHAR_ONE: pause_char_one_reg <= wdata_i;
          `UIEP_A_PAUSE_CHAR_TWO: pause_char_two_reg <= wdata_i;
          default: ;
        endcase
      end
    end
  end

  // =====================================
  // sticky flags; a set in the clearing
  // cycle wins so no event is lost
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      ovr_reg <= 1'b0;
      lsr_int_reg <= 1'b0;
      tx_int_reg <= 1'b0;
      xoff_int_reg <= 1'b0;
      flow_int_reg <= 1'b0;
      tx_low_reg <= 1'b0;
      head_err_reg <= 1'b0;
      rts_n_reg <= 1'b1;
      cts_n_reg <= 1'b1;
    end else begin
      tx_low_reg <= tx_low;
      head_err_reg <= head_bad;
      rts_n_reg <= rts_n_i;
      cts_n_reg <= cts_n_i;
      // overrun cleared by a line status read
      if (rx_overrun_i) begin
        ovr_reg <= 1'b1; // RULE_06
      end else if (rd_lsr) begin
        ovr_reg <= 1'b0;
      end
      if (lsr_set) begin
        lsr_int_reg <= 1'b1; // RULE_13
      end else if (rd_lsr) begin
        lsr_int_reg <= 1'b0;
      end
      // tx ready cleared by source read or holding write
      if (tx_set) begin
        tx_int_reg <= 1'b1; // RULE_11
      end else if (isr_tx_ack || thr_wr_o) begin
        tx_int_reg <= 1'b0;
      end
      // pause char cleared by source read or resume char
      if (xoff_det_i && mask_reg[5] && enh_en) begin
        xoff_int_reg <= 1'b1; // RULE_18
      end else if (isr_xoff_ack || xon_det_i) begin
        xoff_int_reg <= 1'b0;
      end
      // flow edges cleared by modem status read
      if (flow_set) begin
        flow_int_reg <= 1'b1; // RULE_19 RULE_20
      end else if (msr_rd_o) begin
        flow_int_reg <= 1'b0;
      end
    end
  end

  // =====================================
  // interrupt output, one cycle behind the sources
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= any_src; // RULE_21
    end
  end

  // =====================================
  // read mux; answer lands one cycle after rd_i
  // holding and modem bytes live outside, read as zero here
  reg [7:0] rd_val;
  always @* begin
    rd_val = 8'h00;
    if (enh_bank) begin
      case (addr_i)
        `UIEP_A_TRG: rd_val = {1'b0, rx_level_i};
        `UIEP_A_FEATURE_CONTROL: rd_val = feature_control_reg;
        `UIEP_A_EFR: rd_val = efr_reg;
        `UIEP_A_LCR: rd_val = lcr_reg;
        `UIEP_A_RESUME_CHAR_ONE: rd_val = resume_char_one_reg;
        `UIEP_A_RESUME_CHAR_TWO: rd_val = resume_char_two_reg;
        `UIEP_A_PAUSE_CHAR_ONE: rd_val = pause_char_one_reg;
        `UIEP_A_PAUSE_CHAR_TWO: rd_val = pause_char_two_reg;
        default: rd_val = 8'h00;
      endcase
    end else begin
      case (addr_i)
        `UIEP_A_MASK: rd_val = div_bank ? `UIEP_DEV_ID : mask_reg;
        `UIEP_A_ISR: rd_val = {fifo_en, fifo_en, isr_code}; // RULE_03
        `UIEP_A_LCR: rd_val = lcr_reg;
        `UIEP_A_LSR: rd_val = lsr_val; // RULE_05
        `UIEP_A_SPR: rd_val = spr_reg;
        default: rd_val = 8'h00;
      endcase
    end
  end

  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      rdata_o <= rd_val;
    end
  end

endmodule // uiep_core

// [uiep_host.sv]
module uiep_host (
  input wire sys_clk_i,
  input wire [7:0] rdata_i,
  output logic [2:0] addr_o,
  output logic [7:0] wdata_o,
  output logic rd_o,
  output logic wr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // idle bus; data scrambled on release so stale values never match
  initial begin
    addr_o = 3'h0;
    wdata_o = 8'hA5;
    rd_o = 1'b0;
    wr_o = 1'b0;
  end
  task automatic put(input logic [2:0] a, input logic [7:0] v);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= v;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~v;
  endtask
  // read data lands at the taking edge
  task automatic get(input logic [2:0] a, output logic [7:0] v);
    @(posedge sys_clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
    #1;
    v = rdata_i;
  endtask
endmodule // uiep_host

// [uiep_map.vh]
`ifndef UIEP_MAP_VH
`define UIEP_MAP_VH
// =====================================
// register offsets, normal bank
`define UIEP_A_DATA 3'h0
`define UIEP_A_MASK 3'h1
`define UIEP_A_ISR 3'h2
`define UIEP_A_LCR 3'h3
`define UIEP_A_LSR 3'h5
`define UIEP_A_MSR 3'h6
`define UIEP_A_SPR 3'h7
// =====================================
// register offsets, enhanced bank
`define UIEP_A_TRG 3'h0
`define UIEP_A_FEATURE_CONTROL 3'h1
`define UIEP_A_EFR 3'h2
`define UIEP_A_RESUME_CHAR_ONE 3'h4
`define UIEP_A_RESUME_CHAR_TWO 3'h5
`define UIEP_A_PAUSE_CHAR_ONE 3'h6
`define UIEP_A_PAUSE_CHAR_TWO 3'h7
`define UIEP_LCR_ENH 8'hBF
// =====================================
// field positions
`define UIEP_LCR_DIV 7
`define UIEP_EFR_ENH 4
`define UIEP_FEATURE_CONTROL_EXTENDED_MODE_REG 6
`define UIEP_EXTENDED_MODE_REG_IMD 6
`define UIEP_FCR_EN 0
// =====================================
// interrupt source codes
`define UIEP_ISR_LSR 6'h06
`define UIEP_ISR_RXD 6'h04
`define UIEP_ISR_TX 6'h02
`define UIEP_ISR_MSR 6'h00
`define UIEP_ISR_XOFF 6'h10
`define UIEP_ISR_FLOW 6'h20
`define UIEP_ISR_NONE 6'h01
// =====================================
// reset values
`define UIEP_RST_BYTE 8'h00
`define UIEP_RST_LCR 8'h03
// arbitrary identification value
`define UIEP_DEV_ID 8'h5A
`endif

// [uiep_monitor.sv]
module uiep_monitor (
  input wire sys_clk_i,
  input wire rst_i,
  input wire [2:0] addr_i,
  input wire [7:0] wdata_i,
  input wire rd_i,
  input wire wr_i,
  input wire [7:0] rdata_o,
  input wire [6:0] rx_level_i,
  input wire [2:0] rx_head_err_i,
  input wire rx_fifo_err_i,
  input wire rx_overrun_i,
  input wire thr_empty_i,
  input wire tx_empty_i,
  input wire irq_o,
  input wire fifo_en_o,
  input wire sleep_en_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ====================
  // shadow copies of host writes and of the overrun flag
  reg [7:0] lcr_reg;
  reg [7:0] mask_reg;
  reg efr_reg;
  reg ovr_reg;
  wire lsr_rd = rd_i && lcr_reg != 8'hBF && addr_i == 3'h5;
  wire msk_wr = wr_i && !lcr_reg[7] && addr_i == 3'h1;
  wire w4 = wdata_i[4];
  // upper mask bits only move while enhanced mode is on
  always @(posedge sys_clk_i) begin
    if (rst_i) begin
      lcr_reg <= 8'h03;
      mask_reg <= 8'h00;
      efr_reg <= 1'b0;
      ovr_reg <= 1'b0;
    end else begin
      if (wr_i && addr_i == 3'h3) lcr_reg <= wdata_i;
      if (wr_i && addr_i == 3'h2 && lcr_reg == 8'hBF) efr_reg <= w4;
      if (msk_wr) mask_reg <= {efr_reg ? wdata_i[7:4] : mask_reg[7:4], wdata_i[3:0]};
      ovr_reg <= rx_overrun_i | (ovr_reg & !lsr_rd);
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // ====================
  // status and interrupt checks
  a_ready_bit: assert property (lsr_rd |=> rdata_o[0] == ($past(rx_level_i) != 7'h00))
    else $error("ready bit");
  a_overrun_flag: assert property (lsr_rd |=> rdata_o[1] == $past(ovr_reg))
    else $error("overrun bit");
  a_head_err: assert property (lsr_rd |=> rdata_o[4:2] == ($past(rx_level_i) != 0 ? $past(rx_head_err_i) : 3'h0))
    else $error("error bits");
  a_tx_bits: assert property (lsr_rd |=> rdata_o[6:5] == {$past(tx_empty_i), $past(thr_empty_i)})
    else $error("tx bits");
  a_global_err: assert property (lsr_rd |=> rdata_o[7] == ($past(rx_fifo_err_i) && $past(fifo_en_o)))
    else $error("global error bit");
  a_sleep_gate: assert property (msk_wr |=> sleep_en_o == ($past(efr_reg) ? $past(w4) : $past(sleep_en_o)))
    else $error("sleep gate");
  a_masked_quiet: assert property ((mask_reg & 8'hEF) == 8'h00 [*2] |-> !irq_o)
    else $error("irq while masked");
  a_tx_at_once: assert property (msk_wr && wdata_i[1] && !mask_reg[1] && thr_empty_i && !fifo_en_o |=> ##1 irq_o)
    else $error("no tx irq");
  cover property (lsr_rd && ovr_reg);
  cover property (msk_wr && efr_reg && w4);
  cover property (irq_o && fifo_en_o);
endmodule // uiep_monitor
bind uiep_core uiep_monitor i_uiep_monitor (.sys_clk_i, .rst_i, .addr_i, .wdata_i, .rd_i, .wr_i, .rdata_o,
  .rx_level_i, .rx_head_err_i, .rx_fifo_err_i, .rx_overrun_i, .thr_empty_i, .tx_empty_i, .irq_o, .fifo_en_o,
  .sleep_en_o);
